// ---- hw/irq_entry_defs.svh ----
// Constants for the interrupt entry and exit block
`ifndef IRQ_ENTRY_DEFS_SVH
`define IRQ_ENTRY_DEFS_SVH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_VTB 12'h008
`define OFS_ISB 12'h00C
`define OFS_SAVED 12'h010
`define OFS_PSW 12'h014
`define OFS_ENTRY_PC 12'h018
`define OFS_PEND 12'h01C
`define CTRL_IE_BIT 0
`define CTRL_CP_LSB 8
`define CTRL_SAFETY_BIT 16
`define CTRL_INITLOCK_BIT 17
`define VTB_RST 32'h0000_0000
`define SHIFT_WIDE 5
`define SHIFT_NARROW 3
`define PRIV_SUPER 2'h2
`define PRS_ZERO 2'h0
`define CDC_CLEAR 7'h00
`endif

// ---- hw/irq_entry_pkg.sv ----
// Types shared by the interrupt entry and exit block
`default_nettype none
package irq_entry_pkg;
	typedef logic [7:0] prio_t;
	typedef struct packed {
		logic guard;
		logic gw;
		logic cde;
		logic [6:0] cdc;
		logic on_irq_stack;
		logic [1:0] protection_set_select;
		logic [1:0] priv;
	} psw_s;
	typedef struct packed {
		logic ie;
		prio_t prio;
	} saved_s;
	typedef enum logic [1:0] {OP_NONE, OP_ENABLE, OP_DISABLE, OP_BEGIN} core_op_e;
	typedef enum {ST_IDLE, ST_ENTER, ST_BLOCK} state_e;
endpackage
`default_nettype wire

// ---- hw/irq_entry.sv ----
// CPU interrupt acceptance, handler entry and exception return
//
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none
`include "irq_entry_defs.svh"
module irq_entry
	import irq_entry_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pending_priority,
	input wire logic irq_trigger,
	output logic irq_ack,
	output logic [7:0] ack_priority,
	input wire logic in_trap,
	input wire logic multi_cycle,
	input wire logic icw_write,
	input wire logic [1:0] core_op,
	input wire logic [7:0] op_priority,
	input wire logic op_done,
	input wire logic ret_op,
	input wire logic [31:0] current_pc,
	output logic [31:0] return_link_reg,
	output logic [31:0] stack_ptr_reg,
	output logic [31:0] entry_pc,
	output logic entry_pulse,
	output logic save_upper,
	output logic save_lower,
	output logic restore_upper
);
	state_e state_r;
	logic ie_r;
	prio_t cur_prio_r;
	saved_s saved_r;
	psw_s psw_r;
	logic [31:0] vtb_r;
	logic [31:0] isb_r;
	logic safety_cfg_r;
	logic init_open_r;
	logic op_busy_r;
	prio_t taken_r;
	logic aw_ok_r;
	logic w_ok_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	logic rd_fire;
	logic accept;
	logic [31:0] vec_addr;
	logic [31:0] base_clr;
	logic [31:0] wmask;
	logic [31:0] status_word;
	logic icw_bus_wr;
	logic [1:0] wr_resp;

	// Clean OR only if software kept overlapping base bits zero
	assign base_clr = {vtb_r[31:1], 1'b0};
	always_comb begin
		if (!vtb_r[0]) begin
			vec_addr = base_clr | ({24'h000000, pending_priority} << `SHIFT_WIDE);
		end else begin
			vec_addr = base_clr | ({24'h000000, pending_priority} << `SHIFT_NARROW);
		end
	end

	// Hold entry off rather than drop a bus write of these words
	assign icw_bus_wr = wr_fire && (awaddr_r == `OFS_CTRL || awaddr_r == `OFS_SAVED
		|| awaddr_r == `OFS_PSW);

	// Zero priority never exceeds current, so it never wins
	assign accept = (state_r == ST_IDLE) && irq_trigger && ie_r
		&& (pending_priority > cur_prio_r) && (pending_priority != 8'h00)
		&& !in_trap && !multi_cycle && !icw_write && !icw_bus_wr
		&& !op_busy_r && (core_op_e'(core_op) == OP_NONE);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
		end else if (clk_en) begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						state_r <= ST_ENTER;
					end
				end
				// Two blocking cycles, ST_ENTER then ST_BLOCK, cover handler entry
				ST_ENTER: state_r <= ST_BLOCK;
				ST_BLOCK: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			op_busy_r <= 1'b0;
		end else if (clk_en) begin
			if (core_op_e'(core_op) != OP_NONE) begin
				op_busy_r <= 1'b1;
			end else if (op_done) begin
				op_busy_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			irq_ack <= 1'b0;
			ack_priority <= 8'h00;
			entry_pulse <= 1'b0;
			save_upper <= 1'b0;
			entry_pc <= 32'h0000_0000;
			return_link_reg <= 32'h0000_0000;
			taken_r <= 8'h00;
		end else if (clk_en) begin
			irq_ack <= accept;
			entry_pulse <= accept;
			save_upper <= accept;
			if (accept) begin
				ack_priority <= pending_priority;
				taken_r <= pending_priority;
				entry_pc <= vec_addr;
				return_link_reg <= current_pc;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			save_lower <= 1'b0;
			restore_upper <= 1'b0;
		end else if (clk_en) begin
			save_lower <= (core_op_e'(core_op) == OP_BEGIN);
			restore_upper <= ret_op && !accept;
		end
	end

	// Enable and priority: entry, instructions, return and software writes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			ie_r <= 1'b0;
			cur_prio_r <= 8'h00;
			saved_r <= '0;
		end else if (clk_en) begin
			if (accept) begin
				saved_r.ie <= ie_r;
				ie_r <= 1'b0;
				saved_r.prio <= cur_prio_r;
				cur_prio_r <= pending_priority;
			end else if (ret_op) begin
				cur_prio_r <= saved_r.prio;
				ie_r <= saved_r.ie;
			end else if (core_op_e'(core_op) == OP_ENABLE) begin
				ie_r <= 1'b1;
			end else if (core_op_e'(core_op) == OP_DISABLE) begin
				ie_r <= 1'b0;
			end else if (core_op_e'(core_op) == OP_BEGIN) begin
				ie_r <= 1'b1;
				cur_prio_r <= op_priority;
			end else if (wr_fire && awaddr_r == `OFS_CTRL) begin
				if (wstrb_r[0]) begin
					ie_r <= wdata_r[`CTRL_IE_BIT];
				end
				if (wstrb_r[1]) begin
					cur_prio_r <= wdata_r[`CTRL_CP_LSB +: 8];
				end
			end else if (wr_fire && awaddr_r == `OFS_SAVED) begin
				if (wstrb_r[0]) begin
					saved_r.prio <= wdata_r[7:0];
				end
				if (wstrb_r[1]) begin
					saved_r.ie <= wdata_r[8];
				end
			end
		end
	end

	// Status word and stack pointer on entry
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			psw_r <= '0;
			stack_ptr_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (accept) begin
				if (!psw_r.on_irq_stack) begin
					stack_ptr_reg <= isb_r;
				end
				psw_r.on_irq_stack <= 1'b1;
				psw_r.priv <= `PRIV_SUPER;
				psw_r.protection_set_select <= `PRS_ZERO;
				psw_r.cdc <= `CDC_CLEAR;
				psw_r.cde <= 1'b1;
				psw_r.guard <= safety_cfg_r;
				psw_r.gw <= 1'b0;
			end else if (wr_fire && awaddr_r == `OFS_PSW) begin
				psw_r <= wdata_r[14:0];
			end
		end
	end

	// Configuration; vector base guarded by init lock
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			vtb_r <= `VTB_RST;
			isb_r <= 32'h0000_0000;
			safety_cfg_r <= 1'b0;
			init_open_r <= 1'b1;
		end else if (clk_en && wr_fire) begin
			if (awaddr_r == `OFS_VTB && init_open_r) begin
				vtb_r <= wdata_r & wmask | vtb_r & ~wmask;
			end
			if (awaddr_r == `OFS_ISB) begin
				isb_r <= wdata_r & wmask | isb_r & ~wmask;
			end
			if (awaddr_r == `OFS_CTRL && wstrb_r[2]) begin
				safety_cfg_r <= wdata_r[`CTRL_SAFETY_BIT];
				init_open_r <= wdata_r[`CTRL_INITLOCK_BIT];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{wstrb_r[i]}};
		end
	end

	// AXI4-Lite write path: address and data latched in either order
	assign wr_fire = aw_ok_r && w_ok_r && !s_axi_bvalid;
	// Read-only and unmapped words refuse writes alike
	always_comb begin
		case (awaddr_r)
			`OFS_CTRL, `OFS_VTB, `OFS_ISB, `OFS_SAVED, `OFS_PSW: wr_resp = 2'h0;
			default: wr_resp = 2'h2;
		endcase
	end
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 12'h000;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (clk_en) begin
			s_axi_awready <= !aw_ok_r && s_axi_awvalid && !s_axi_awready;
			s_axi_wready <= !w_ok_r && s_axi_wvalid && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bresp <= wr_resp;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign status_word = {7'h00, taken_r, state_r != ST_IDLE, op_busy_r, psw_r};
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (clk_en) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case ({s_axi_araddr[11:2], 2'h0})
					`OFS_CTRL: s_axi_rdata <= {14'h0000, init_open_r, safety_cfg_r,
						cur_prio_r, 7'h00, ie_r};
					`OFS_STATUS: s_axi_rdata <= status_word;
					`OFS_VTB: s_axi_rdata <= vtb_r;
					`OFS_ISB: s_axi_rdata <= isb_r;
					`OFS_SAVED: s_axi_rdata <= {23'h000000, saved_r.ie, saved_r.prio};
					`OFS_PSW: s_axi_rdata <= {17'h00000, psw_r};
					`OFS_ENTRY_PC: s_axi_rdata <= entry_pc;
					`OFS_PEND: s_axi_rdata <= {23'h000000, irq_trigger, pending_priority};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verification/request_arbiter_model.sv ----
// Behavioural request arbiter facing the core
`default_nettype none
module request_arbiter_model (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic post,
	input wire logic [7:0] post_prio,
	input wire logic irq_ack,
	input wire logic [7:0] ack_priority,
	output logic [7:0] pending_priority,
	output logic irq_trigger
);
	logic [7:0] src_a_r;
	logic [7:0] src_b_r;
	// Two sources only, enough to show the winner
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			src_a_r <= 8'h00;
			src_b_r <= 8'h00;
		end else if (irq_ack && src_a_r == ack_priority) begin
			src_a_r <= 8'h00;
		end else if (irq_ack && src_b_r == ack_priority) begin
			src_b_r <= 8'h00;
		end else if (post && src_a_r == 8'h00) begin
			src_a_r <= post_prio;
		end else if (post) begin
			src_b_r <= post_prio;
		end
	end
	assign pending_priority = (src_a_r > src_b_r) ? src_a_r : src_b_r;
	assign irq_trigger = pending_priority != 8'h00;
endmodule
`default_nettype wire

// ---- verification/irq_entry_props.sv ----
// Port checker for the interrupt entry and exit block
`default_nettype none
module irq_entry_props (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic irq_ack,
	input wire logic [7:0] ack_priority,
	input wire logic [7:0] pending_priority,
	input wire logic irq_trigger,
	input wire logic in_trap,
	input wire logic [1:0] core_op,
	input wire logic ret_op,
	input wire logic [31:0] current_pc,
	input wire logic [31:0] return_link_reg,
	input wire logic save_lower,
	input wire logic restore_upper
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Entry and block states refuse two cycles
	sequence s_refuse;
		!irq_ack [*2];
	endsequence
	a_ack_spacing: assert property (irq_ack |=> s_refuse)
		else $error("ack too soon");
	a_ack_cause: assert property (
		irq_ack |-> $past(irq_trigger) && $past(pending_priority) != 8'h00)
		else $error("ack without request");
	a_ack_prio: assert property (irq_ack |-> ack_priority == $past(pending_priority))
		else $error("wrong taken priority");
	a_trap_block: assert property (irq_ack |-> !$past(in_trap))
		else $error("ack during trap");
	a_op_block: assert property (irq_ack |-> $past(core_op) == 2'h0)
		else $error("ack during op");
	a_link_load: assert property (irq_ack |-> return_link_reg == $past(current_pc))
		else $error("return link wrong");
	a_lower_save: assert property (core_op == 2'h3 |=> save_lower)
		else $error("no lower save");
	a_exit_restore: assert property (ret_op |=> restore_upper || irq_ack)
		else $error("no restore");
endmodule
bind irq_entry irq_entry_props i_props (.mclk, .rstn, .irq_ack, .ack_priority,
	.pending_priority, .irq_trigger, .in_trap, .core_op, .ret_op, .current_pc,
	.return_link_reg, .save_lower, .restore_upper);
`default_nettype wire

// ---- verification/test_irq_entry.sv ----
// Self-checking bench for the interrupt entry and exit block
`default_nettype none
`include "irq_entry_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module test_irq_entry;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, rstn = 1'b0, clk_en = 1'b1, in_trap = 1'b0, multi_cycle = 1'b0;
	logic icw_write = 1'b0, op_done = 1'b0, ret_op = 1'b0, post = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, current_pc = 32'h8000_1234;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] core_op = 2'h0;
	logic [7:0] op_priority = 8'h00, post_prio = 8'h00;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_trigger;
	logic irq_ack, entry_pulse, save_upper, save_lower, restore_upper;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pending_priority, ack_priority;
	logic [31:0] s_axi_rdata, return_link_reg, stack_ptr_reg, entry_pc;
	int err_count = 0, checks = 0;
	always #5 mclk = ~mclk;
	irq_entry i_dut (.mclk, .rstn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pending_priority, .irq_trigger, .irq_ack,
		.ack_priority, .in_trap, .multi_cycle, .icw_write, .core_op, .op_priority, .op_done,
		.ret_op, .current_pc, .return_link_reg, .stack_ptr_reg, .entry_pc, .entry_pulse,
		.save_upper, .save_lower, .restore_upper);
	request_arbiter_model i_arb (.mclk, .rstn, .post, .post_prio, .irq_ack, .ack_priority,
		.pending_priority, .irq_trigger);
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n = 1);
		repeat (n) @(posedge mclk);
	endtask
	task automatic hang();
		err_count++;
		results();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 20) hang();
		`CHK("bresp", r, s_axi_bresp)
		tick();
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, e, input logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 20) hang();
		`CHK("rdata", e, s_axi_rdata & m)
		`CHK("rresp", r, s_axi_rresp)
		tick();
	endtask
	task automatic raise(input logic [7:0] p);
		post <= 1'b1;
		post_prio <= p;
		tick();
		post <= 1'b0;
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			tick();
			`CHK("irq_ack", 1'b0, irq_ack)
		end
	endtask
	task automatic take(input logic [7:0] p, input logic [31:0] pc);
		int n;
		for (n = 0; n < 30 && irq_ack !== 1'b1; n++) tick();
		if (n == 30) hang();
		`CHK("ack_priority", p, ack_priority)
		`CHK("entry_pc", pc, entry_pc)
		`CHK("return_link", current_pc, return_link_reg)
		`CHK("entry_pulse", 1'b1, entry_pulse)
		`CHK("save_upper", 1'b1, save_upper)
	endtask
	// Completion is held back so the refusal window can be seen
	task automatic do_op(input logic [1:0] op, input logic [7:0] p, input int n);
		core_op <= op;
		op_priority <= p;
		tick();
		core_op <= 2'h0;
		quiet(n);
		op_done <= 1'b1;
		tick();
		op_done <= 1'b0;
	endtask
	task automatic t_entry();
		rd(`OFS_VTB, 32'hFFFF_FFFF, 32'h0, 2'h0);
		rd(12'h040, 32'hFFFF_FFFF, 32'h0, 2'h2);
		wr(`OFS_VTB, 32'h0001_0000, 4'hF, 2'h0);
		wr(`OFS_ISB, 32'h0000_4000, 4'hF, 2'h0);
		wr(`OFS_CTRL, 32'h0003_0001, 4'hF, 2'h0);
		wr(12'h040, 32'h0000_0000, 4'hF, 2'h2);
		raise(8'h05);
		take(8'h05, 32'h0001_00A0);
		`CHK("stack_ptr", 32'h0000_4000, stack_ptr_reg)
		rd(`OFS_CTRL, 32'h0000_FFFF, 32'h0000_0500, 2'h0);
		rd(`OFS_SAVED, 32'h0000_01FF, 32'h0000_0100, 2'h0);
		rd(`OFS_PSW, 32'h0000_7FFF, 32'h0000_5012, 2'h0);
		$display("entry test done");
	endtask
	task automatic t_compare();
		do_op(2'h1, 8'h00, 1);
		raise(8'h05);
		quiet(6);
		in_trap <= 1'b1;
		raise(8'h07);
		quiet(6);
		wr(`OFS_ISB, 32'h0000_8000, 4'hF, 2'h0);
		in_trap <= 1'b0;
		take(8'h07, 32'h0001_00E0);
		`CHK("stack_ptr", 32'h0000_4000, stack_ptr_reg)
		ret_op <= 1'b1;
		tick();
		ret_op <= 1'b0;
		tick(2);
		rd(`OFS_CTRL, 32'h0000_FFFF, 32'h0000_0501, 2'h0);
		do_op(2'h2, 8'h00, 1);
		rd(`OFS_CTRL, 32'h0000_FFFF, 32'h0000_0500, 2'h0);
		$display("compare and return test done");
	endtask
	task automatic t_begin();
		wr(`OFS_VTB, 32'h0002_0001, 4'hF, 2'h0);
		do_op(2'h3, 8'h02, 4);
		multi_cycle <= 1'b1;
		quiet(3);
		multi_cycle <= 1'b0;
		icw_write <= 1'b1;
		quiet(3);
		icw_write <= 1'b0;
		take(8'h05, 32'h0002_0028);
		wr(`OFS_CTRL, 32'h0000_0000, 4'h4, 2'h0);
		wr(`OFS_VTB, 32'h0003_0000, 4'hF, 2'h0);
		rd(`OFS_VTB, 32'hFFFF_FFFF, 32'h0002_0001, 2'h0);
		$display("begin and lock test done");
	endtask
	initial begin
		tick(2);
		rstn <= 1'b1;
		tick();
		t_entry();
		t_compare();
		t_begin();
		results();
	end
endmodule
`default_nettype wire
